// ===== i2cm_master.sv
// Behaviour
// - master engine runs only with master mode selected and enable set
// - pins are pulled low only by enabling the driver, else released
// - start-seen and stop-seen clear on reset and while disabled
// - bus is claimed only when stop was seen or bus is idle
// - firmware master mode: only start/stop detection, software moves pins
// - port flag set on start, stop, byte, acknowledge, repeated start
// - buffer write while busy is dropped and sets write collision
// - own start/stop generation suspends start/stop detection
// - end of start/stop generation clears request bit and sets port flag
// - master produces every clock pulse, start and stop
// - transfer ends with stop or repeated start keeping the bus
// - write: first byte is 7-bit address with direction zero
// - read: first byte is 7-bit address with direction one
// - transmit eight bits msb first then sample slave acknowledge
// - receive eight bits then drive acknowledge to slave
// - clock rate comes from programmable baud reload
// - start is data falling, stop data rising, with clock high
// - stop valid only after clock low once; start and restart need no clock low
`timescale 1ns/10ps
module i2cm_master
   import i2cm_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [4:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [4:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic irq
);
   i2cm_state_all_type s_q;
   i2cm_state_all_type s_d;
   logic wr_go;
   logic rd_go;
   logic hw_mode;
   logic fw_mode;
   logic gen_busy;
   logic det_start;
   logic det_stop;
   logic tick;

   // bus handshakes: address and data are taken together
   assign wr_go = s_q.awready && awvalid && wvalid;
   assign rd_go = s_q.arready && arvalid;
   assign hw_mode = s_q.ctl.en && (s_q.ctl.mode == MODE_MASTER);
   assign fw_mode = s_q.ctl.en && (s_q.ctl.mode == MODE_FW_MASTER);
   // own start/stop sequences blind the detector, else it flags itself
   assign gen_busy = (s_q.st == ST_START_A) || (s_q.st == ST_START_B) || (s_q.st == ST_STOP_A)
      || (s_q.st == ST_STOP_B) || (s_q.st == ST_STOP_C);
   assign det_start = !gen_busy && scl_i && s_q.scl_p && s_q.sda_p && !sda_i;
   assign det_stop = !gen_busy && scl_i && s_q.scl_p && !s_q.sda_p && sda_i && s_q.scl_low_seen;
   // baud phase ends; high phases wait out slave stretching
   assign tick = (s_q.cnt == 8'h00) && ((s_q.st != ST_BIT_HI && s_q.st != ST_RSTART_B
      && s_q.st != ST_STOP_B) || scl_i);

   always_comb
   begin
      s_d = s_q;
      s_d.scl_p = scl_i;
      s_d.sda_p = sda_i;
      // baud rate counter reloads on every phase change
      if (s_q.cnt != 8'h00)
      begin
         if (s_q.st != ST_BIT_HI || scl_i)
         begin
            s_d.cnt = s_q.cnt - 8'h01;
         end
      end
      // register write side
      s_d.awready = 1'b0;
      s_d.wready = 1'b0;
      if (s_q.bvalid && bready)
      begin
         s_d.bvalid = 1'b0;
      end
      if (!s_q.awready && !s_q.bvalid && awvalid && wvalid)
      begin
         s_d.awready = 1'b1;
         s_d.wready = 1'b1;
      end
      if (wr_go)
      begin
         s_d.bvalid = 1'b1;
         s_d.bresp = RESP_OKAY;
         unique case (awaddr)
            OFS_CONTROL:
            begin
               if (wstrb[0])
               begin
                  s_d.ctl.en = wdata[CTL_ENABLE];
                  s_d.ctl.mode = wdata[CTL_MODE_LSB +: 4];
                  s_d.ctl.begin_req = wdata[CTL_BEGIN];
                  s_d.ctl.halt_req = wdata[CTL_HALT];
                  s_d.ctl.rstart_req = wdata[CTL_RESTART];
               end
               if (wstrb[1])
               begin
                  s_d.ctl.recv_req = wdata[CTL_RECV];
                  s_d.ctl.ack_data = wdata[CTL_ACK_DATA];
                  s_d.ctl.ack_req = wdata[CTL_ACK_REQ];
                  s_d.ctl.fw_scl = wdata[CTL_FW_SCL];
                  s_d.ctl.fw_sda = wdata[CTL_FW_SDA];
               end
            end
            OFS_BAUD:
            begin
               if (wstrb[0])
               begin
                  s_d.baud = wdata[7:0];
               end
            end
            OFS_BUFFER:
            begin
               // no queuing: only an idle held bus accepts a byte
               if (hw_mode && s_q.st == ST_HOLD && !s_q.ctl.begin_req && !s_q.ctl.halt_req
                  && !s_q.ctl.rstart_req && !s_q.ctl.recv_req && !s_q.ctl.ack_req)
               begin
                  s_d.shift = wdata[7:0]; // address and direction bit come from software
                  s_d.kind = KIND_TX;
                  s_d.bitcnt = BITS_TX;
                  s_d.st = ST_BIT_LO;
                  s_d.cnt = s_q.baud;
               end
               else
               begin
                  s_d.ist[IRQ_WRITE_COLLISION_FLAG] = 1'b1;
               end
            end
            OFS_IRQ_STAT:
            begin
               if (wstrb[0])
               begin
                  s_d.ist = s_d.ist & ~wdata[1:0];
               end
            end
            OFS_IRQ_MASK:
            begin
               if (wstrb[0])
               begin
                  s_d.imask = wdata[1:0];
               end
            end
            OFS_STATUS:
            begin
               s_d.bvalid = 1'b1;
            end
            default:
            begin
               s_d.bresp = RESP_SLVERR;
            end
         endcase
      end
      // register read side
      s_d.arready = 1'b0;
      if (s_q.rvalid && rready)
      begin
         s_d.rvalid = 1'b0;
      end
      if (!s_q.arready && !s_q.rvalid && arvalid)
      begin
         s_d.arready = 1'b1;
      end
      if (rd_go)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp = RESP_OKAY;
         s_d.rdata = 32'h0000_0000;
         unique case (araddr)
            OFS_CONTROL: s_d.rdata[12:0] = {s_q.ctl.fw_sda, s_q.ctl.fw_scl, s_q.ctl.ack_req,
               s_q.ctl.ack_data, s_q.ctl.recv_req, s_q.ctl.rstart_req, s_q.ctl.halt_req,
               s_q.ctl.begin_req, s_q.ctl.mode, s_q.ctl.en};
            OFS_STATUS: s_d.rdata[3:0] = {(s_q.st != ST_IDLE), s_q.ack_stat, s_q.stop_seen, s_q.start_seen};
            OFS_BAUD: s_d.rdata[7:0] = s_q.baud;
            OFS_BUFFER: s_d.rdata[7:0] = s_q.rxbuf;
            OFS_IRQ_STAT: s_d.rdata[1:0] = s_q.ist;
            OFS_IRQ_MASK: s_d.rdata[1:0] = s_q.imask;
            default: s_d.rresp = RESP_SLVERR;
         endcase
      end
      // start/stop detection stays alive in firmware mode too
      if (!scl_i)
      begin
         s_d.scl_low_seen = 1'b1;
      end
      if ((hw_mode || fw_mode) && det_start)
      begin
         s_d.start_seen = 1'b1;
         s_d.stop_seen = 1'b0;
         s_d.scl_low_seen = 1'b0;
         s_d.ist[IRQ_PORT] = 1'b1;
      end
      if ((hw_mode || fw_mode) && det_stop)
      begin
         s_d.stop_seen = 1'b1;
         s_d.start_seen = 1'b0;
         s_d.ist[IRQ_PORT] = 1'b1;
      end
      // engine; every phase lasts baud+1 cycles
      if (tick && hw_mode)
      begin
         s_d.cnt = s_q.baud;
         unique case (s_q.st)
            ST_IDLE:
            begin
               if (s_q.ctl.begin_req && (s_q.stop_seen || !s_q.start_seen))
               begin
                  s_d.st = ST_START_A;
               end
            end
            ST_START_A: s_d.st = ST_START_B;
            ST_START_B:
            begin
               s_d.st = ST_HOLD;
               s_d.ctl.begin_req = 1'b0;
               s_d.ctl.rstart_req = 1'b0;
               s_d.start_seen = 1'b1;
               s_d.stop_seen = 1'b0;
               s_d.scl_low_seen = 1'b0;
               s_d.ist[IRQ_PORT] = 1'b1;
            end
            ST_HOLD:
            begin
               // master keeps the clock low between bytes
               if (s_q.ctl.rstart_req)
               begin
                  s_d.st = ST_RSTART_A;
               end
               else if (s_q.ctl.halt_req)
               begin
                  s_d.st = ST_STOP_A;
               end
               else if (s_q.ctl.recv_req)
               begin
                  s_d.kind = KIND_RX;
                  s_d.bitcnt = BITS_RX;
                  s_d.st = ST_BIT_LO;
               end
               else if (s_q.ctl.ack_req)
               begin
                  s_d.kind = KIND_ACK;
                  s_d.bitcnt = BITS_ACK;
                  s_d.st = ST_BIT_LO;
               end
            end
            ST_RSTART_A: s_d.st = ST_RSTART_B;
            ST_RSTART_B: s_d.st = ST_START_A;
            ST_STOP_A: s_d.st = ST_STOP_B;
            ST_STOP_B: s_d.st = ST_STOP_C;
            ST_STOP_C:
            begin
               s_d.st = ST_IDLE;
               s_d.ctl.halt_req = 1'b0;
               s_d.stop_seen = 1'b1;
               s_d.start_seen = 1'b0;
               s_d.ist[IRQ_PORT] = 1'b1;
            end
            ST_BIT_LO: s_d.st = ST_BIT_HI;
            ST_BIT_HI:
            begin
               // sample at end of clock high
               if (s_q.kind == KIND_TX && s_q.bitcnt == BITS_ACK)
               begin
                  s_d.ack_stat = sda_i;
               end
               else if (s_q.kind != KIND_ACK)
               begin
                  s_d.shift = {s_q.shift[6:0], sda_i};
               end
               s_d.bitcnt = s_q.bitcnt - 4'h1;
               s_d.st = ST_BIT_LO;
               if (s_q.bitcnt == BITS_ACK)
               begin
                  s_d.st = ST_HOLD;
                  s_d.ist[IRQ_PORT] = 1'b1;
                  s_d.ctl.recv_req = 1'b0;
                  s_d.ctl.ack_req = 1'b0;
                  if (s_q.kind == KIND_RX)
                  begin
                     s_d.rxbuf = {s_q.shift[6:0], sda_i};
                  end
               end
            end
            default: s_d.st = ST_IDLE;
         endcase
      end
      // pin drivers: enable only to pull low, release otherwise
      s_d.scl_oe = 1'b0;
      s_d.sda_oe = 1'b0;
      if (fw_mode)
      begin
         s_d.scl_oe = s_d.ctl.fw_scl;
         s_d.sda_oe = s_d.ctl.fw_sda;
      end
      else if (hw_mode)
      begin
         unique case (s_d.st)
            ST_START_A: s_d.sda_oe = 1'b1;
            ST_START_B, ST_STOP_A:
            begin
               s_d.sda_oe = 1'b1;
               s_d.scl_oe = 1'b1;
            end
            ST_STOP_B: s_d.sda_oe = 1'b1;
            ST_RSTART_A, ST_HOLD: s_d.scl_oe = 1'b1;
            ST_BIT_LO, ST_BIT_HI:
            begin
               s_d.scl_oe = (s_d.st == ST_BIT_LO);
               if (s_d.kind == KIND_TX && s_d.bitcnt != BITS_ACK)
               begin
                  s_d.sda_oe = !s_d.shift[7];
               end
               else if (s_d.kind == KIND_ACK)
               begin
                  s_d.sda_oe = !s_q.ctl.ack_data;
               end
            end
            default:
            begin
               s_d.scl_oe = 1'b0;
            end
         endcase
         // data waits one cycle after the clock is pulled low, else a slave sees a false start or stop
         if (s_d.scl_oe && !s_q.scl_oe)
         begin
            s_d.sda_oe = s_q.sda_oe;
         end
      end
      // disabling the port drops the engine and the bus flags
      if (!s_d.ctl.en)
      begin
         s_d.start_seen = 1'b0;
         s_d.stop_seen = 1'b0;
         s_d.st = ST_IDLE;
      end
      s_d.irq = |(s_d.ist & s_d.imask);
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
         s_q.baud <= BAUD_RESET;
         s_q.scl_p <= 1'b1;
         s_q.sda_p <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign awready = s_q.awready;
   assign wready = s_q.wready;
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign arready = s_q.arready;
   assign rvalid = s_q.rvalid;
   assign rdata = s_q.rdata;
   assign rresp = s_q.rresp;
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = s_q.scl_oe;
   assign sda_oe = s_q.sda_oe;
   assign irq = s_q.irq;

   // checks
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence seq_start_done;
      (s_q.st == ST_START_B && s_q.ctl.en) ##1 (s_q.st == ST_HOLD && s_q.ctl.en);
   endsequence
   sequence seq_stop_done;
      (s_q.st == ST_STOP_C && s_q.ctl.en) ##1 (s_q.st == ST_IDLE && s_q.ctl.en);
   endsequence
   chk_start_flag: assert property (seq_start_done |-> s_q.ist[IRQ_PORT] && !s_q.ctl.begin_req)
      else $error("start end did not clear request and flag");
   chk_stop_flag: assert property (seq_stop_done |-> s_q.ist[IRQ_PORT] && s_q.stop_seen)
      else $error("stop end did not flag");
   chk_write_collision_flag_set: assert property (wr_go && awaddr == OFS_BUFFER && s_q.st != ST_HOLD
      |=> s_q.ist[IRQ_WRITE_COLLISION_FLAG] && (s_q.st != ST_BIT_LO || $past(s_q.st) == ST_BIT_LO || $past(s_q.st) == ST_BIT_HI))
      else $error("busy buffer write not refused");
   chk_write_collision_flag_sticky: assert property (s_q.ist[IRQ_WRITE_COLLISION_FLAG] && !(wr_go && awaddr == OFS_IRQ_STAT)
      |=> s_q.ist[IRQ_WRITE_COLLISION_FLAG])
      else $error("collision flag lost");
   chk_disable_clear: assert property (!s_q.ctl.en |-> !s_q.start_seen && !s_q.stop_seen)
      else $error("bus flags not cleared while disabled");
   chk_claim_gate: assert property (s_q.st == ST_IDLE ##1 s_q.st == ST_START_A
      |-> $past(s_q.stop_seen) || !$past(s_q.start_seen))
      else $error("bus claimed while busy");
   chk_fw_pins: assert property (fw_mode ##1 fw_mode |-> sda_oe == s_q.ctl.fw_sda && scl_oe == s_q.ctl.fw_scl)
      else $error("firmware pins not followed");
   chk_detect_hold: assert property (s_q.st == ST_STOP_B && s_q.ctl.en
      |=> !s_q.ctl.en || s_q.start_seen == $past(s_q.start_seen))
      else $error("detection active during own stop");
   chk_bit_clock: assert property (s_q.st == ST_BIT_LO ##1 s_q.st == ST_BIT_LO |-> scl_oe)
      else $error("clock not driven low in bit low phase");
   chk_irq_level: assert property (irq == |(s_q.ist & s_q.imask))
      else $error("interrupt output mismatch");
endmodule

// ===== i2cm_pkg.sv
package i2cm_pkg;
   // register byte addresses
   localparam logic [4:0] OFS_CONTROL = 5'h00;
   localparam logic [4:0] OFS_STATUS = 5'h04;
   localparam logic [4:0] OFS_BAUD = 5'h08;
   localparam logic [4:0] OFS_BUFFER = 5'h0C;
   localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
   // port_control_one field positions
   localparam int CTL_ENABLE = 0;
   localparam int CTL_MODE_LSB = 1;
   localparam int CTL_BEGIN = 5;
   localparam int CTL_HALT = 6;
   localparam int CTL_RESTART = 7;
   localparam int CTL_RECV = 8;
   localparam int CTL_ACK_DATA = 9;
   localparam int CTL_ACK_REQ = 10;
   localparam int CTL_FW_SCL = 11;
   localparam int CTL_FW_SDA = 12;
   // port_mode_select encodings
   localparam logic [3:0] MODE_MASTER = 4'h8;
   localparam logic [3:0] MODE_FW_MASTER = 4'hB;
   // interrupt status bits
   localparam int IRQ_PORT = 0;
   localparam int IRQ_WRITE_COLLISION_FLAG = 1;
   // reset values and counts
   localparam logic [7:0] BAUD_RESET = 8'h31;
   localparam logic [3:0] BITS_TX = 4'h9;
   localparam logic [3:0] BITS_RX = 4'h8;
   localparam logic [3:0] BITS_ACK = 4'h1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0, ST_START_A = 4'h1, ST_START_B = 4'h2, ST_RSTART_A = 4'h3,
      ST_RSTART_B = 4'h4, ST_STOP_A = 4'h5, ST_STOP_B = 4'h6, ST_STOP_C = 4'h7,
      ST_BIT_LO = 4'h8, ST_BIT_HI = 4'h9, ST_HOLD = 4'hA
   } i2cm_state_type;

   typedef enum logic [1:0] {
      KIND_TX = 2'h0, KIND_RX = 2'h1, KIND_ACK = 2'h2
   } i2cm_kind_type;

   typedef struct packed {
      logic en;
      logic [3:0] mode;
      logic begin_req;
      logic halt_req;
      logic rstart_req;
      logic recv_req;
      logic ack_data;
      logic ack_req;
      logic fw_scl;
      logic fw_sda;
   } i2cm_ctrl_type;

   typedef struct packed {
      i2cm_ctrl_type ctl;
      logic [7:0] baud;
      logic [7:0] cnt;
      logic [7:0] shift;
      logic [7:0] rxbuf;
      logic [3:0] bitcnt;
      i2cm_kind_type kind;
      i2cm_state_type st;
      logic start_seen;
      logic stop_seen;
      logic scl_low_seen;
      logic ack_stat;
      logic scl_p;
      logic sda_p;
      logic [1:0] ist;
      logic [1:0] imask;
      logic irq;
      logic scl_oe;
      logic sda_oe;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } i2cm_state_all_type;
endpackage

// ===== i2cm_slave_model.sv
`timescale 1ns/10ps
module i2cm_slave_model
   import i2cm_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2A,
   parameter logic [7:0] TX_BYTE = 8'hC3
)
(
   input wire logic scl,
   input wire logic sda,
   output logic sda_pull,
   output logic [7:0] last_rx,
   output logic mst_ack
);
   logic [7:0] sh;
   logic is_addr;
   logic matched;
   logic sending;
   logic go_send;
   logic active;
   int cnt;

   // released lines float high through the pull-up
   initial
   begin
      sda_pull = 1'h0;
      last_rx = 8'h00;
      mst_ack = 1'h0;
      active = 1'h0;
      matched = 1'h0;
   end

   // start or repeated start restarts the frame
   always @(negedge sda)
      if (scl)
      begin
         active = 1'h1;
         cnt = 0;
         is_addr = 1'h1;
         sending = 1'h0;
         go_send = 1'h0;
      end

   // stop ends the frame
   always @(posedge sda)
      if (scl)
         active = 1'h0;

   // sample on rising clock, nine bits a frame
   always @(posedge scl)
      if (active)
      begin
         if (cnt < 8)
            sh = {sh[6:0], sda};
         if (cnt == 8)
         begin
            if (sending)
            begin
               mst_ack = sda;
               go_send = !sda;
            end
            sending = 1'h0;
            cnt = 0;
         end
         else
            cnt++;
      end

   // drive only while clock low, so no false start or stop
   always @(negedge scl)
      if (active)
      begin
         if (cnt == 8 && !sending)
         begin
            if (is_addr)
            begin
               matched = (sh[7:1] == DEV_ADDR);
               go_send = matched && sh[0];
            end
            else if (matched)
               last_rx = sh;
            is_addr = 1'h0;
            sda_pull = matched;
         end
         else if (cnt == 0 && go_send)
         begin
            sending = 1'h1;
            go_send = 1'h0;
            sda_pull = !TX_BYTE[7];
         end
         else if (sending && cnt < 8)
            sda_pull = !TX_BYTE[7 - cnt];
         else
            sda_pull = 1'h0;
      end
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top
   import i2cm_pkg::*;
();
   typedef struct packed {logic wr; logic [4:0] a; logic [31:0] d; logic [31:0] exp; logic [1:0] resp;} i2cm_row_type;
   localparam logic [6:0] DEV = 7'h2A;
   localparam logic [31:0] HW = 32'h1 | (32'(MODE_MASTER) << CTL_MODE_LSB);
   localparam logic [31:0] FW = 32'h1 | (32'(MODE_FW_MASTER) << CTL_MODE_LSB);
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic [4:0] awaddr = 5'h00;
   logic [4:0] araddr = 5'h00;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, irq, sda_pull, mst_ack;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [7:0] last_rx;
   wire logic scl;
   wire logic sda;
   int err_total = 0, check_count = 0, n_start = 0, n_stop = 0, s0, p0;
   i2cm_row_type rows [11] = '{
      '{1'h0, OFS_BAUD, 32'h0, 32'h31, RESP_OKAY}, '{1'h0, OFS_CONTROL, 32'h0, 32'h0, RESP_OKAY},
      '{1'h0, OFS_IRQ_STAT, 32'h0, 32'h0, RESP_OKAY}, '{1'h1, OFS_BAUD, 32'h4, 32'h0, RESP_OKAY},
      '{1'h0, OFS_BAUD, 32'h0, 32'h4, RESP_OKAY}, '{1'h1, OFS_IRQ_MASK, 32'h1, 32'h0, RESP_OKAY},
      '{1'h0, OFS_IRQ_MASK, 32'h0, 32'h1, RESP_OKAY}, '{1'h1, OFS_STATUS, 32'hF, 32'h0, RESP_OKAY},
      '{1'h0, OFS_STATUS, 32'h0, 32'h0, RESP_OKAY}, '{1'h1, 5'h18, 32'h1, 32'h0, RESP_SLVERR},
      '{1'h0, 5'h18, 32'h0, 32'h0, RESP_SLVERR}};

   // open-drain wires, pulled up
   assign scl = !scl_oe;
   assign sda = !sda_oe && !sda_pull;

   always #25 sys_clk = !sys_clk;

   // count bus conditions on the wire
   always @(negedge sda)
      if (scl === 1'h1)
         n_start++;
   always @(posedge sda)
      if (scl === 1'h1)
         n_stop++;

   i2cm_master u_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
      .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .irq(irq));

   i2cm_slave_model #(.DEV_ADDR(DEV), .TX_BYTE(8'hC3)) u_slave (
      .scl(scl), .sda(sda), .sda_pull(sda_pull), .last_rx(last_rx), .mst_ack(mst_ack));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // each channel released only at the edge that takes it
   task automatic wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic aw_done = 1'h0;
      logic w_done = 1'h0;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!(aw_done && w_done))
      begin
         @(posedge sys_clk);
         aw_done = aw_done | (awready === 1'h1);
         w_done = w_done | (wready === 1'h1);
         if (aw_done)
            awvalid <= 1'h0;
         if (w_done)
            wvalid <= 1'h0;
      end
      while (bvalid !== 1'h1)
         @(posedge sys_clk);
      rs = bresp;
      bready <= 1'h0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge sys_clk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      while (rvalid !== 1'h1)
         @(posedge sys_clk);
      v = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask

   // bounded wait for the port flag, then clear it
   task automatic wait_flag;
      int n = 0;
      while (irq !== 1'h1 && n < 3000)
      begin
         @(posedge sys_clk);
         n++;
      end
      chk(32'(irq), 32'h1);
      wr(OFS_IRQ_STAT, 32'h1, r);
   endtask

   task automatic xfer(input logic [4:0] a, input logic [31:0] v);
      wr(a, v, r);
      wait_flag;
   endtask

   // pin writes get a few cycles so detection sees the settled lines
   task automatic fw(input logic [31:0] v);
      wr(OFS_CONTROL, v, r);
      repeat (8) @(posedge sys_clk);
   endtask

   initial
   begin
      repeat (30000) @(posedge sys_clk);
      err_total++;
      stop_test;
   end

   initial
   begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'h1;
      for (int i = 0; i < 11; i++)
      begin
         if (rows[i].wr)
            wr(rows[i].a, rows[i].d, r);
         else
         begin
            rd(rows[i].a, d, r);
            chk(d, rows[i].exp);
         end
         chk(32'(r), 32'(rows[i].resp));
      end
      // begin request with port disabled stays idle
      wr(OFS_CONTROL, (HW & ~32'h1) | (32'h1 << CTL_BEGIN), r);
      repeat (20) @(posedge sys_clk);
      chk(32'({sda_oe, irq}), 32'h0);
      // start, buffer write during it must collide
      s0 = n_start;
      wr(OFS_CONTROL, HW | (32'h1 << CTL_BEGIN), r);
      wr(OFS_BUFFER, 32'h5A, r);
      wait_flag;
      rd(OFS_CONTROL, d, r);
      chk(32'(d[CTL_BEGIN]), 32'h0);
      chk(n_start - s0, 1);
      rd(OFS_IRQ_STAT, d, r);
      chk(d, 32'h2);
      wr(OFS_IRQ_STAT, 32'h2, r);
      xfer(OFS_BUFFER, 32'({DEV, 1'h0}));
      rd(OFS_STATUS, d, r);
      chk(32'(d[2]), 32'h0);
      xfer(OFS_BUFFER, 32'hA5);
      chk(32'(last_rx), 32'hA5);
      p0 = n_stop;
      xfer(OFS_CONTROL, HW | (32'h1 << CTL_HALT));
      rd(OFS_CONTROL, d, r);
      chk(32'(d[CTL_HALT]), 32'h0);
      chk(n_stop - p0, 1);
      // absent address is refused, then repeated start into a read
      xfer(OFS_CONTROL, HW | (32'h1 << CTL_BEGIN));
      xfer(OFS_BUFFER, 32'({~DEV, 1'h0}));
      rd(OFS_STATUS, d, r);
      chk(32'(d[2]), 32'h1);
      s0 = n_start;
      p0 = n_stop;
      xfer(OFS_CONTROL, HW | (32'h1 << CTL_RESTART));
      chk(n_start - s0, 1);
      chk(n_stop - p0, 0);
      xfer(OFS_BUFFER, 32'({DEV, 1'h1}));
      rd(OFS_STATUS, d, r);
      chk(32'(d[2]), 32'h0);
      for (int k = 0; k < 2; k++)
      begin
         xfer(OFS_CONTROL, HW | (32'h1 << CTL_RECV));
         rd(OFS_BUFFER, d, r);
         chk(d, 32'hC3);
         xfer(OFS_CONTROL, HW | (32'(k) << CTL_ACK_DATA) | (32'h1 << CTL_ACK_REQ));
         chk(32'(mst_ack), 32'(k));
      end
      xfer(OFS_CONTROL, HW | (32'h1 << CTL_HALT));
      // firmware master: software moves pins, hardware only detects
      wr(OFS_CONTROL, 32'h0, r);
      fw(FW | (32'h1 << CTL_FW_SDA));
      chk(32'({scl_oe, sda_oe}), 32'h1);
      rd(OFS_STATUS, d, r);
      chk(d & 32'h3, 32'h1);
      wr(OFS_IRQ_MASK, 32'h0, r);
      repeat (2) @(posedge sys_clk);
      chk(32'(irq), 32'h0);
      wr(OFS_IRQ_MASK, 32'h1, r);
      wait_flag;
      fw(FW);
      rd(OFS_STATUS, d, r);
      chk(d & 32'h3, 32'h1);
      // start seen without stop: bus is not free
      fw(HW | (32'h1 << CTL_BEGIN));
      repeat (20) @(posedge sys_clk);
      chk(32'(sda_oe), 32'h0);
      fw(FW | (32'h1 << CTL_FW_SDA));
      fw(FW | (32'h1 << CTL_FW_SDA) | (32'h1 << CTL_FW_SCL));
      chk(32'({scl_oe, sda_oe}), 32'h3);
      fw(FW | (32'h1 << CTL_FW_SDA));
      fw(FW);
      rd(OFS_STATUS, d, r);
      chk(32'(d[1]), 32'h1);
      fw(32'h0);
      rd(OFS_STATUS, d, r);
      chk(d & 32'h3, 32'h0);
      stop_test;
   end
endmodule
